/* hdl/mpors_defs.svh */
// timing and encoding constants for the power-off and reset sequencer
`ifndef MPORS_DEFS_SVH
`define MPORS_DEFS_SVH
`define MPORS_CLK_MHZ 125
`define MPORS_PWRON_MIN_US 1
`define MPORS_PWRON_CYC ((`MPORS_PWRON_MIN_US * `MPORS_CLK_MHZ))
`define MPORS_RESET_MIN_US 1
`define MPORS_RESET_CYC ((`MPORS_RESET_MIN_US * `MPORS_CLK_MHZ))
`define MPORS_SLOW_HZ 32768
`define MPORS_SLOW_HALF_CYC (125000000 / (2 * `MPORS_SLOW_HZ))
`define MPORS_SLOW_VALID_CYC (4 * `MPORS_SLOW_HALF_CYC)
`define MPORS_CNT_W 16
`define MPORS_VARIANT_CORE_ONLY 1'b0
`define MPORS_VARIANT_CORE_PMU 1'b1
`endif

/* hdl/mpors_pkg.sv */
// types for the power-off and reset sequencer
package mpors_pkg;
    typedef enum logic [2:0] {
        MPORS_NOT_POWERED,
        MPORS_POWER_OFF,
        MPORS_RUN,
        MPORS_SAVE,
        MPORS_SHUTDOWN,
        MPORS_HW_RESET
    } mpors_state_t;
endpackage

/* hdl/mpors_low_pulse.sv */
// low-level qualifier: pulses once when an input has stayed low long enough
`timescale 1ns/1ns
`include "mpors_defs.svh"
module mpors_low_pulse #(
    parameter logic [`MPORS_CNT_W-1:0] MIN_CYC = 16'h0001
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic sig_n_i, // monitored line, active low
    output logic valid_o, // one-cycle pulse when low time reached
    output logic low_o // level: low time reached and still low
);
    logic [`MPORS_CNT_W-1:0] cnt_reg;
    logic [`MPORS_CNT_W-1:0] cnt_next;
    logic hit_reg;
    logic hit_next;

    // count low cycles, saturate at threshold
    always_comb begin
        cnt_next = cnt_reg;
        hit_next = hit_reg;
        if (sig_n_i) begin
            cnt_next = '0;
            hit_next = 1'b0;
        end else if (cnt_reg < MIN_CYC) begin
            cnt_next = cnt_reg + 16'h0001;
        end else begin
            hit_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
        end
    end

    assign valid_o = hit_next & ~hit_reg;
    assign low_o = hit_reg;
endmodule // mpors_low_pulse

/* hdl/mpors_seq.sv */
// power-off, reset and slow clock sequencer of a cellular module
`timescale 1ns/1ns
`include "mpors_defs.svh"
module mpors_seq
    import mpors_pkg::*;
#(
    parameter logic VARIANT_PMU = `MPORS_VARIANT_CORE_ONLY,
    parameter logic HAS_SLOW_IN = 1'b1
) (
    input wire logic clk_sys_i, // system clock 125 MHz
    input wire logic rst_b_i, // async reset, active low
    input wire logic main_supply_ok_i, // main supply present
    input wire logic power_off_command_i, // pulse: power-off command decoded
    input wire logic functional_reset_command_i, // pulse: functional reset command
    input wire logic power_save_config_command_i, // level: power saving enabled
    input wire logic power_on_request_n_i, // power-on request, active low
    input wire logic hw_reset_n_i, // hardware reset line, active low
    input wire logic hw_reset_n_oe_i, // high while host drives reset line
    input wire logic slow_clock_in_i, // external 32 kHz reference
    input wire logic save_done_i, // parameter save and detach finished
    input wire logic core_idle_req_i, // processor asks for low-power idle
    output logic ok_resp_o, // pulse: OK answer on command interface
    output logic save_req_o, // level: save parameters and detach
    output logic core_reset_n_o, // processor core reset, active low
    output logic io_supply_on_o, // digital I/O supply output
    output logic pins_tristate_o, // all digital pins tri-stated
    output logic pins_reset_state_o, // pins held in reset state
    output logic backup_rtc_supply_o, // backup RTC supply
    output logic idle_en_o, // low-power idle allowed
    output logic rtc_run_o, // RTC timekeeping running
    output logic slow_clock_out_o, // 32 kHz output
    output logic [2:0] state_o // sequencer state
);
    mpors_state_t state_reg, state_next;
    logic fres_reg, fres_next;
    logic ok_reg, ok_next;
    logic [`MPORS_CNT_W-1:0] div_reg, div_next;
    logic sclk_reg, sclk_next;
    logic [`MPORS_CNT_W-1:0] mon_reg, mon_next;
    logic sin_d_reg, sin_d_next;
    logic sin_ok_reg, sin_ok_next;
    logic pwron_ok, rst_ok, rst_low, rst_line_n, sin_edge;

    // undriven reset line reads high
    assign rst_line_n = hw_reset_n_oe_i ? hw_reset_n_i : 1'b1;

    mpors_low_pulse #(.MIN_CYC(16'(`MPORS_PWRON_CYC))) u_pwron (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .sig_n_i(power_on_request_n_i),
        .valid_o(pwron_ok),
        .low_o()
    );

    mpors_low_pulse #(.MIN_CYC(16'(`MPORS_RESET_CYC))) u_hwrst (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .sig_n_i(rst_line_n),
        .valid_o(rst_ok),
        .low_o(rst_low)
    );

    // main sequencer
    always_comb begin
        state_next = state_reg;
        fres_next = fres_reg;
        ok_next = 1'b0;
        if (!main_supply_ok_i) begin
            state_next = MPORS_NOT_POWERED;
            fres_next = 1'b0;
        end else begin
            unique case (state_reg)
                MPORS_NOT_POWERED: begin
                    state_next = MPORS_POWER_OFF;
                end
                MPORS_POWER_OFF: begin
                    if (pwron_ok || rst_ok) begin
                        state_next = MPORS_RUN;
                    end
                end
                MPORS_RUN: begin
                    if (rst_ok) begin
                        state_next = MPORS_HW_RESET;
                    end else if (power_off_command_i) begin
                        state_next = MPORS_SAVE;
                        fres_next = 1'b0;
                        ok_next = 1'b1;
                    end else if (functional_reset_command_i) begin
                        state_next = MPORS_SAVE;
                        fres_next = 1'b1;
                        ok_next = 1'b1;
                    end
                end
                MPORS_SAVE: begin
                    if (rst_ok) begin
                        state_next = MPORS_HW_RESET;
                    end else if (save_done_i) begin
                        state_next = MPORS_SHUTDOWN;
                    end
                end
                MPORS_SHUTDOWN: begin
                    state_next = fres_reg ? MPORS_RUN : MPORS_POWER_OFF;
                    fres_next = 1'b0;
                end
                MPORS_HW_RESET: begin
                    if (!rst_low) begin
                        state_next = MPORS_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= MPORS_NOT_POWERED;
            fres_reg <= 1'b0;
            ok_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fres_reg <= fres_next;
            ok_reg <= ok_next;
        end
    end

    // slow clock divider and input activity monitor
    always_comb begin
        div_next = div_reg;
        sclk_next = sclk_reg;
        mon_next = mon_reg;
        sin_d_next = slow_clock_in_i;
        sin_ok_next = sin_ok_reg;
        if (io_supply_on_o && state_reg != MPORS_HW_RESET) begin
            if (div_reg >= 16'(`MPORS_SLOW_HALF_CYC - 1)) begin
                div_next = '0;
                sclk_next = ~sclk_reg;
            end else begin
                div_next = div_reg + 16'h0001;
            end
        end else begin
            div_next = '0;
            sclk_next = 1'b0;
        end
        if (sin_edge) begin
            mon_next = '0;
            sin_ok_next = 1'b1;
        end else if (mon_reg >= 16'(`MPORS_SLOW_VALID_CYC)) begin
            sin_ok_next = 1'b0;
        end else begin
            mon_next = mon_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_reg <= '0;
            sclk_reg <= 1'b0;
            mon_reg <= '0;
            sin_d_reg <= 1'b0;
            sin_ok_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            mon_reg <= mon_next;
            sin_d_reg <= sin_d_next;
            sin_ok_reg <= sin_ok_next;
        end
    end

    assign sin_edge = slow_clock_in_i & ~sin_d_reg;

    // supply and pin controls per state and variant
    always_comb begin
        io_supply_on_o = 1'b0;
        pins_tristate_o = 1'b1;
        pins_reset_state_o = 1'b0;
        core_reset_n_o = 1'b0;
        unique case (state_reg)
            MPORS_RUN, MPORS_SAVE: begin
                io_supply_on_o = 1'b1;
                pins_tristate_o = 1'b0;
                core_reset_n_o = 1'b1;
            end
            MPORS_SHUTDOWN: begin
                io_supply_on_o = fres_reg;
                pins_tristate_o = ~fres_reg;
                pins_reset_state_o = fres_reg;
            end
            MPORS_HW_RESET: begin
                io_supply_on_o = (VARIANT_PMU == `MPORS_VARIANT_CORE_ONLY);
                pins_tristate_o = (VARIANT_PMU != `MPORS_VARIANT_CORE_ONLY);
                pins_reset_state_o = (VARIANT_PMU == `MPORS_VARIANT_CORE_ONLY);
            end
            default: begin
            end
        endcase
    end

    assign backup_rtc_supply_o = (state_reg != MPORS_NOT_POWERED);
    assign ok_resp_o = ok_reg;
    assign save_req_o = (state_reg == MPORS_SAVE);
    assign slow_clock_out_o = HAS_SLOW_IN ? sclk_reg : 1'b0;
    assign idle_en_o = core_idle_req_i && power_save_config_command_i &&
                       (HAS_SLOW_IN ? sin_ok_reg : 1'b1) && core_reset_n_o;
    assign rtc_run_o = (HAS_SLOW_IN ? sin_ok_reg : backup_rtc_supply_o);
    assign state_o = state_reg;
endmodule // mpors_seq

/* bench/mpors_seq_props.sv */
// assertion checker for the power-off and reset sequencer
`timescale 1ns/1ns
module mpors_seq_chk #(
    parameter logic VARIANT_PMU = 1'b0
) (
    input wire logic clk_sys_i, // clock
    input wire logic rst_b_i, // reset
    input wire logic main_supply_ok_i, // supply
    input wire logic power_off_command_i, // off cmd
    input wire logic power_on_request_n_i, // wake
    input wire logic hw_reset_n_i, // reset line
    input wire logic hw_reset_n_oe_i, // line driven
    input wire logic power_save_config_command_i, // saving
    input wire logic ok_resp_o, // ok
    input wire logic save_req_o, // save
    input wire logic core_reset_n_o, // core reset
    input wire logic io_supply_on_o, // io supply
    input wire logic pins_tristate_o, // tristate
    input wire logic backup_rtc_supply_o, // backup
    input wire logic idle_en_o, // idle
    input wire logic rtc_run_o, // rtc
    input wire logic slow_clock_out_o, // slow out
    input wire logic [2:0] state_o // state
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // accepted power-off command, and a wake from power-off
    sequence s_off_cmd;
        state_o == 3'h2 && power_off_command_i && main_supply_ok_i
            && (hw_reset_n_i || !hw_reset_n_oe_i);
    endsequence
    sequence s_wake;
        state_o == 3'h1 ##1 state_o == 3'h2;
    endsequence
    a_off_ok: assert property (s_off_cmd |=> ok_resp_o && state_o == 3'h3)
        else $error("off command not answered");
    a_ok_saving: assert property (ok_resp_o |-> save_req_o && core_reset_n_o)
        else $error("ok without running routine");
    a_off_state: assert property (state_o == 3'h1 |->
        pins_tristate_o && !io_supply_on_o && backup_rtc_supply_o)
        else $error("bad power-off outputs");
    a_save_first: assert property (state_o == 3'h4 |-> $past(state_o) == 3'h3)
        else $error("shutdown without save");
    a_shut_reset: assert property (state_o == 3'h4 |-> !core_reset_n_o && !save_req_o)
        else $error("core not held in reset at routine end");
    a_supply_loss: assert property (!main_supply_ok_i |=> state_o == 3'h0)
        else $error("supply loss ignored");
    a_hw_variant: assert property (state_o == 3'h5 |-> !save_req_o && !core_reset_n_o
        && io_supply_on_o != VARIANT_PMU && pins_tristate_o == VARIANT_PMU)
        else $error("bad hardware reset outputs");
    a_wake_cause: assert property (s_wake |-> !$past(power_on_request_n_i, 3)
        || ($past(hw_reset_n_oe_i, 3) && !$past(hw_reset_n_i, 3)))
        else $error("wake without event");
    a_idle_cond: assert property (idle_en_o |-> power_save_config_command_i && rtc_run_o)
        else $error("idle without conditions");
    a_slow_stop: assert property (state_o == 3'h1 && $past(state_o) == 3'h1
        |=> $stable(slow_clock_out_o))
        else $error("slow output runs when off");
endmodule // mpors_seq_chk
bind mpors_seq mpors_seq_chk #(.VARIANT_PMU(VARIANT_PMU)) chk_u (.*);

/* bench/mpors_host_model.sv */
// host side model: save handshake partner and external slow reference
`timescale 1ns/1ns
module mpors_host_model (
    input wire logic clk_sys_i, // clock
    input wire logic save_req_i, // save request
    input wire logic slow_run_i, // reference enabled
    input wire logic [7:0] save_dly_i, // answer delay
    output logic save_done_o, // save finished
    output logic slow_clock_o // slow reference
);
    int cnt = 0;
    int sc = 0;
    initial save_done_o = 1'b0;
    initial slow_clock_o = 1'b0;
    // answer after a varying delay, never a fixed phase length
    always @(negedge clk_sys_i) begin
        cnt <= save_req_i ? cnt + 1 : 0;
        save_done_o <= save_req_i && cnt >= save_dly_i;
    end
    // half period 1907 cycles, frozen while disabled
    always @(negedge clk_sys_i) begin
        sc <= (sc == 1906) ? 0 : sc + 1;
        if (slow_run_i && sc == 1906) slow_clock_o <= !slow_clock_o;
    end
endmodule // mpors_host_model

/* bench/mpors_seq_tb_top.sv */
// testbench for the power-off and reset sequencer
`timescale 1ns/1ns
module mpors_seq_tb_top;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, sup = 1'b1, off_c = 1'b0, fun_c = 1'b0;
    logic ps = 1'b0, pon_n = 1'b1, rn = 1'b1, roe = 1'b0, srun = 1'b0;
    logic sdone, sclk, ok, sreq, crn, io, tst, prs, bk, ide, rtc, sco, v;
    logic [2:0] st;
    logic [7:0] dly = 8'h03;
    int n_fail = 0, n_tests = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    mpors_seq dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .main_supply_ok_i(sup),
        .power_off_command_i(off_c), .functional_reset_command_i(fun_c),
        .power_save_config_command_i(ps), .power_on_request_n_i(pon_n), .hw_reset_n_i(rn),
        .hw_reset_n_oe_i(roe), .slow_clock_in_i(sclk), .save_done_i(sdone),
        .core_idle_req_i(1'b1), .ok_resp_o(ok), .save_req_o(sreq), .core_reset_n_o(crn),
        .io_supply_on_o(io), .pins_tristate_o(tst), .pins_reset_state_o(prs),
        .backup_rtc_supply_o(bk), .idle_en_o(ide), .rtc_run_o(rtc),
        .slow_clock_out_o(sco), .state_o(st));
    mpors_host_model host_u (.clk_sys_i(clk_sys_i), .save_req_i(sreq), .slow_run_i(srun),
        .save_dly_i(dly), .save_done_o(sdone), .slow_clock_o(sclk));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wst(input logic [2:0] s);
        for (int i = 0; i < 2000 && st !== s; i++) @(negedge clk_sys_i);
    endtask
    task automatic results;
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // short request pulse is ignored, a long one wakes the module
    task automatic t_wake;
        chk(st, 3'h1);
        pon_n = 1'b0;
        cyc(60);
        pon_n = 1'b1;
        cyc(5);
        chk(st, 3'h1);
        pon_n = 1'b0;
        cyc(130);
        pon_n = 1'b1;
        wst(3'h2);
        chk({st, io, tst}, {3'h2, 2'b10});
    endtask
    // power-off (pw=1) or functional reset (pw=0) command
    task automatic t_cmd(input logic pw);
        chk(io, 1'b1);
        off_c = pw;
        fun_c = !pw;
        cyc(1);
        off_c = 1'b0;
        fun_c = 1'b0;
        chk({ok, st, sreq}, {1'b1, 3'h3, 1'b1});
        for (int i = 0; i < 2000 && io !== !pw; i++) @(negedge clk_sys_i);
        wst(pw ? 3'h1 : 3'h2);
        chk({st, io, tst, bk}, {pw ? 3'h1 : 3'h2, !pw, pw, 1'b1});
    endtask
    // idle and rtc follow the slow reference and power saving
    task automatic t_slow;
        ps = 1'b1;
        srun = 1'b1;
        cyc(8000);
        chk({ide, rtc}, 2'b11);
        v = sco;
        cyc(1907);
        chk(sco, !v);
        ps = 1'b0;
        cyc(2);
        chk(ide, 1'b0);
        ps = 1'b1;
        srun = 1'b0;
        cyc(8000);
        chk({ide, rtc}, 2'b00);
    endtask
    // hardware reset during a slow save, then an undriven low line
    task automatic t_hw;
        dly = 8'hff;
        off_c = 1'b1;
        cyc(1);
        off_c = 1'b0;
        roe = 1'b1;
        rn = 1'b0;
        cyc(130);
        chk({st, io, prs, sreq, crn}, {3'h5, 4'b1100});
        rn = 1'b1;
        roe = 1'b0;
        dly = 8'h03;
        wst(3'h2);
        rn = 1'b0;
        cyc(130);
        chk(st, 3'h2);
        rn = 1'b1;
    endtask
    // functional reset command refused when off, slow output frozen, reset-line wake, then supply loss
    task automatic t_off;
        fun_c = 1'b1;
        cyc(1);
        fun_c = 1'b0;
        chk({ok, st}, {1'b0, 3'h1});
        v = sco;
        cyc(4000);
        chk(sco, v);
        roe = 1'b1;
        rn = 1'b0;
        cyc(130);
        rn = 1'b1;
        roe = 1'b0;
        cyc(2);
        chk({st, io}, {3'h2, 1'b1});
        sup = 1'b0;
        cyc(2);
        chk(st, 3'h0);
    endtask
    // main sequence
    initial begin
        cyc(2);
        rst_b_i = 1'b1;
        cyc(2);
        t_wake();
        t_cmd(1'b0);
        t_slow();
        t_hw();
        t_cmd(1'b1);
        t_off();
        results();
    end
    // watchdog
    initial begin
        #400000;
        n_fail++;
        results();
    end
endmodule // mpors_seq_tb_top
